// File: core_model.sv
// Far side model: peripheral sources feeding the pending lines
`timescale 1ns/1ps
`default_nettype none
module core_model #(
  parameter int LAG = 1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [27:0] normal_src,
  input  wire logic [27:0] fast_src,
  output logic [27:0]      normal_pending,
  output logic [27:0]      fast_pending
);
  logic [27:0] n_q [LAG];
  logic [27:0] f_q [LAG];
  // Sources reach the pending lines after LAG clocks
  always_ff @(posedge aclk) begin
    for (int i = 0; i < LAG; i++) begin
      n_q[i] <= !aresetn ? 28'h000_0000 : (i == 0 ? normal_src : n_q[i-1]);
      f_q[i] <= !aresetn ? 28'h000_0000 : (i == 0 ? fast_src : f_q[i-1]);
    end
  end
  assign normal_pending = n_q[LAG-1];
  assign fast_pending   = f_q[LAG-1];
endmodule
`default_nettype wire

// File: interrupt_priority_nesting.sv
// Priority fields, nesting control and in-service levels of the vectored
// interrupt controller, with an AXI4-Lite register slave
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_nesting (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [27:0] normal_pending,
  input  wire logic [27:0] fast_pending,
  output logic             normal_irq,
  output logic             fast_irq,
  output logic [4:0]       fast_source,
  output logic             event_irq
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] prio_q [4];
  logic [1:0]  ctrl_q;
  logic [7:0]  in_serv_q, in_serv_d;
  logic [15:0] base_q;
  logic [1:0]  ev_stat_q, ev_mask_q;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q, awaddr_q, wdata_q;
  logic        aw_full_q, w_full_q;
  logic        normal_irq_q, fast_irq_q, event_irq_q;
  logic [4:0]  fast_source_q;

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  logic aw_take, w_take, do_write, ar_take;
  logic aw_full_d, w_full_d, rvalid_d;
  assign aw_take   = awvalid && awready_q;
  assign w_take    = wvalid && wready_q;
  assign do_write  = aw_full_q && w_full_q && !bvalid_q;
  assign ar_take   = arvalid && arready_q;
  assign aw_full_d = (aw_full_q && !do_write) || aw_take;
  assign w_full_d  = (w_full_q && !do_write) || w_take;
  assign rvalid_d  = ar_take || (rvalid_q && !rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      awaddr_q  <= irq_nest_pkg::REG_RESET;
      wdata_q   <= irq_nest_pkg::REG_RESET;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= !aw_full_d;
      wready_q  <= !w_full_d;
      if (aw_take) begin
        awaddr_q <= awaddr;
      end
      if (w_take) begin
        wdata_q <= wdata;
      end
    end
  end

  logic [3:0] wstrb_q;

  // Byte lanes merged into the stored word
  function automatic logic [31:0] lanes(input logic [31:0] old,
                                        input logic [31:0] nw);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (wstrb_q[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstrb_q <= 4'h0;
    end else if (w_take) begin
      wstrb_q <= wstrb;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [3:0] wr_prio;
  logic       wr_ctrl, wr_serv, wr_base, wr_stat, wr_mask, wr_hit;
  logic       rd_vec;
  assign wr_prio[0] = do_write && awaddr_q == irq_nest_pkg::ADDR_PRIO0;
  assign wr_prio[1] = do_write && awaddr_q == irq_nest_pkg::ADDR_PRIO1;
  assign wr_prio[2] = do_write && awaddr_q == irq_nest_pkg::ADDR_PRIO2;
  assign wr_prio[3] = do_write && awaddr_q == irq_nest_pkg::ADDR_PRIO3;
  assign wr_ctrl = do_write && awaddr_q == irq_nest_pkg::ADDR_NEST_CTL;
  assign wr_serv = do_write && awaddr_q == irq_nest_pkg::ADDR_IN_SERV;
  assign wr_base = do_write && awaddr_q == irq_nest_pkg::ADDR_VEC_BASE;
  assign wr_stat = do_write && awaddr_q == irq_nest_pkg::ADDR_EV_STAT;
  assign wr_mask = do_write && awaddr_q == irq_nest_pkg::ADDR_EV_MASK;
  assign wr_hit  = (|wr_prio) || wr_ctrl || wr_serv || wr_base
                || wr_stat || wr_mask;
  assign rd_vec  = ar_take && araddr == irq_nest_pkg::ADDR_VEC_PTR;

  // ----------------------------------------------------------------
  // Priority and control registers
  // ----------------------------------------------------------------
  logic [31:0] prio_mask [4];
  assign prio_mask[0] = irq_nest_pkg::PRIO0_MASK;
  assign prio_mask[1] = irq_nest_pkg::PRIO1_MASK;
  assign prio_mask[2] = irq_nest_pkg::PRIO2_MASK;
  assign prio_mask[3] = irq_nest_pkg::PRIO3_MASK;

  for (genvar r = 0; r < 4; r++) begin : g_prio
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prio_q[r] <= irq_nest_pkg::REG_RESET;
      end else if (wr_prio[r]) begin
        prio_q[r] <= lanes(prio_q[r], wdata_q) & prio_mask[r];
      end
    end
  end

  logic [31:0] ctrl_new, base_new;
  always_comb begin
    ctrl_new = lanes({30'h0, ctrl_q}, wdata_q);
    base_new = lanes({16'h0000, base_q}, wdata_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 2'h0;
      base_q <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_new[1:0];
      end
      if (wr_base) begin
        base_q <= base_new[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-source levels
  // ----------------------------------------------------------------
  logic [2:0] n_lvl [irq_nest_pkg::NUM_SRC];
  logic [2:0] f_lvl [irq_nest_pkg::NUM_SRC];
  for (genvar g = 0; g < irq_nest_pkg::NUM_SRC; g++) begin : g_src
    localparam logic [7:0] F = irq_nest_pkg::SRC_FIELD[g];
    // Levels vanish while prioritisation is off
    assign n_lvl[g] = (F[7] && ctrl_q[irq_nest_pkg::NORMAL_NEST])
                    ? prio_q[F[6:5]][F[4:0] +: 3] : 3'h0;
    assign f_lvl[g] = (F[7] && ctrl_q[irq_nest_pkg::FAST_NEST])
                    ? prio_q[F[6:5]][F[4:0] +: 3] : 3'h0;
  end

  // Winner among unblocked pending sources
  function automatic irq_nest_pkg::pick_t pick(
      input logic [27:0] pend, input logic [2:0] lvl [28],
      input logic [7:0] blk);
    irq_nest_pkg::pick_t s;
    logic [7:0] m;
    s = '0;
    for (int i = 0; i < irq_nest_pkg::NUM_SRC; i++) begin
      m = (8'h02 << lvl[i]) - 8'h01;
      if (pend[i] && (blk & m) == 8'h00
          && (!s.found || lvl[i] < s.level)) begin
        s.found = 1'b1;
        s.id    = 5'(i);
        s.level = lvl[i];
      end
    end
    return s;
  endfunction

  irq_nest_pkg::pick_t nsel, fsel;
  logic [7:0] n_blk;
  assign n_blk = ctrl_q[irq_nest_pkg::NORMAL_NEST] ? in_serv_q : 8'h00;
  assign nsel  = pick(normal_pending, n_lvl, n_blk);
  assign fsel  = pick(fast_pending, f_lvl, 8'h00);

  // ----------------------------------------------------------------
  // In-service levels
  // ----------------------------------------------------------------
  logic       vec_set;
  logic [7:0] serv_clr, set_bit;
  assign vec_set  = rd_vec && ctrl_q[irq_nest_pkg::NORMAL_NEST]
                 && nsel.found;
  assign set_bit  = vec_set ? 8'(8'h01 << nsel.level) : 8'h00;
  // Clearing x & (x-1) drops the lowest index, the highest priority
  assign serv_clr = in_serv_q & (in_serv_q - 8'h01);

  always_comb begin
    in_serv_d = in_serv_q;
    if (wr_serv && wstrb_q[0] && wdata_q[7:0] == irq_nest_pkg::CLEAR_ONE) begin
      in_serv_d = serv_clr;
    end
    in_serv_d = in_serv_d | set_bit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_serv_q <= 8'h00;
    end else begin
      in_serv_q <= in_serv_d;
    end
  end

  // ----------------------------------------------------------------
  // Core requests and events
  // ----------------------------------------------------------------
  logic       fast_wins;
  logic [1:0] ev_set;
  assign fast_wins = fsel.found && ctrl_q == 2'h0;
  assign ev_set    = {fsel.found && !fast_irq_q,
                      nsel.found && !fast_wins && !normal_irq_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal_irq_q  <= 1'b0;
      fast_irq_q    <= 1'b0;
      fast_source_q <= 5'h00;
    end else begin
      normal_irq_q  <= nsel.found && !fast_wins;
      fast_irq_q    <= fsel.found;
      fast_source_q <= fsel.id;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_stat_q   <= 2'h0;
      ev_mask_q   <= 2'h0;
      event_irq_q <= 1'b0;
    end else begin
      // New events win over a write-one clear
      ev_stat_q <= (ev_stat_q & ~(wr_stat && wstrb_q[0] ? wdata_q[1:0] : 2'h0))
                 | ev_set;
      if (wr_mask && wstrb_q[0]) begin
        ev_mask_q <= wdata_q[1:0];
      end
      event_irq_q <= |(ev_stat_q & ev_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Write response and read data
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr)
      irq_nest_pkg::ADDR_PRIO0:    rd_val = prio_q[0];
      irq_nest_pkg::ADDR_PRIO1:    rd_val = prio_q[1];
      irq_nest_pkg::ADDR_PRIO2:    rd_val = prio_q[2];
      irq_nest_pkg::ADDR_PRIO3:    rd_val = prio_q[3];
      irq_nest_pkg::ADDR_NEST_CTL: rd_val = {30'h0, ctrl_q};
      irq_nest_pkg::ADDR_IN_SERV:  rd_val = {24'h0, in_serv_q};
      irq_nest_pkg::ADDR_VEC_BASE: rd_val = {16'h0000, base_q};
      // Pointer into the handler table
      irq_nest_pkg::ADDR_VEC_PTR:  rd_val = {9'h000, base_q, nsel.id, 2'h0};
      irq_nest_pkg::ADDR_EV_STAT:  rd_val = {30'h0, ev_stat_q};
      irq_nest_pkg::ADDR_EV_MASK:  rd_val = {30'h0, ev_mask_q};
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q  <= 1'b0;
      bresp_q   <= irq_nest_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      arready_q <= 1'b0;
      rdata_q   <= irq_nest_pkg::REG_RESET;
      rresp_q   <= irq_nest_pkg::RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? irq_nest_pkg::RESP_OKAY
                           : irq_nest_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      rvalid_q  <= rvalid_d;
      arready_q <= !rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_val;
        rresp_q <= rd_hit ? irq_nest_pkg::RESP_OKAY
                          : irq_nest_pkg::RESP_SLVERR;
      end
    end
  end

  assign awready     = awready_q;
  assign wready      = wready_q;
  assign bvalid      = bvalid_q;
  assign bresp       = bresp_q;
  assign arready     = arready_q;
  assign rvalid      = rvalid_q;
  assign rdata       = rdata_q;
  assign rresp       = rresp_q;
  assign normal_irq  = normal_irq_q;
  assign fast_irq    = fast_irq_q;
  assign fast_source = fast_source_q;
  assign event_irq   = event_irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_prio0_low_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && araddr == irq_nest_pkg::ADDR_PRIO0 |=> rdata_q[3:0] == 4'h0)
    else $error("reserved priority bits read nonzero");

  a_prio3_top_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 prio_q[3][31:15] == 17'h0_0000)
    else $error("reserved upper priority bits set");

  a_plain_no_block: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q[0] |-> nsel.found == |normal_pending && nsel.level == 3'h0)
    else $error("levels or blocking used without nesting");

  a_fast_first: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q == 2'h0 && |fast_pending |=> !normal_irq_q)
    else $error("normal request shown over fast one");

  a_vector_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    vec_set |=> in_serv_q[$past(nsel.level)] && rvalid_q)
    else $error("vector read did not mark level");

  a_level_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[0] && nsel.found
      |-> (in_serv_q & ((8'h02 << nsel.level) - 8'h01)) == 8'h00)
    else $error("blocked level selected");

  a_clear_one: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_serv && wstrb_q[0] && wdata_q[7:0] == 8'hff && !vec_set
      |=> in_serv_q == ($past(in_serv_q) & ($past(in_serv_q) - 8'h01)))
    else $error("in-service clear wrong");

  a_vector_word: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_vec |=> rdata_q[22:7] == $past(base_q) && rdata_q[6:2] == $past(nsel.id)
      && rdata_q[31:23] == 9'h000)
    else $error("vector word layout wrong");

  a_fast_levels: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q[1] && fsel.found |-> fsel.level == 3'h0 && fast_pending[fsel.id])
    else $error("fast levels used while disabled");
endmodule
`default_nettype wire

// File: irq_nest_pkg.sv
// Constants and types for the interrupt priority and nesting block
package irq_nest_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_VEC_BASE = 32'hffff_0014;
  localparam logic [31:0] ADDR_VEC_PTR  = 32'hffff_001c;
  localparam logic [31:0] ADDR_PRIO0    = 32'hffff_0020;
  localparam logic [31:0] ADDR_PRIO1    = 32'hffff_0024;
  localparam logic [31:0] ADDR_PRIO2    = 32'hffff_0028;
  localparam logic [31:0] ADDR_PRIO3    = 32'hffff_002c;
  localparam logic [31:0] ADDR_NEST_CTL = 32'hffff_0030;
  localparam logic [31:0] ADDR_IN_SERV  = 32'hffff_003c;
  localparam logic [31:0] ADDR_EV_STAT  = 32'hffff_0040;
  localparam logic [31:0] ADDR_EV_MASK  = 32'hffff_0044;
  // ----------------------------------------------------------------
  // Writable bits, reset values, commands
  // ----------------------------------------------------------------
  localparam logic [31:0] PRIO0_MASK  = 32'h0777_7770;
  localparam logic [31:0] PRIO1_MASK  = 32'h7777_7707;
  localparam logic [31:0] PRIO2_MASK  = 32'h7777_7777;
  localparam logic [31:0] PRIO3_MASK  = 32'h0000_7777;
  localparam logic [31:0] REG_RESET   = 32'h0000_0000;
  localparam logic [7:0]  CLEAR_ONE   = 8'hff;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          NORMAL_NEST = 0;
  localparam int          FAST_NEST   = 1;
  localparam int          EV_NORMAL   = 0;
  localparam int          EV_FAST     = 1;
  localparam int          NUM_SRC     = 28;
  localparam int          NUM_LVL     = 8;
  // ----------------------------------------------------------------
  // Priority field positions
  // ----------------------------------------------------------------
  localparam logic [4:0] TIMER4_PRIORITY          = 5'h18;
  localparam logic [4:0] TIMER3_PRIORITY          = 5'h14;
  localparam logic [4:0] TIMER2_PRIORITY          = 5'h10;
  localparam logic [4:0] TIMER1_PRIORITY          = 5'h0c;
  localparam logic [4:0] TIMER0_PRIORITY          = 5'h08;
  localparam logic [4:0] SOFT_SOURCE_PRIORITY     = 5'h04;
  localparam logic [4:0] I2C_A_MASTER_PRIORITY    = 5'h1c;
  localparam logic [4:0] SPI_PRIORITY             = 5'h18;
  localparam logic [4:0] UART_PRIORITY            = 5'h14;
  localparam logic [4:0] CONVERTER_PRIORITY       = 5'h10;
  localparam logic [4:0] FLASH_B_PRIORITY         = 5'h0c;
  localparam logic [4:0] FLASH_A_PRIORITY         = 5'h08;
  localparam logic [4:0] SUPPLY_MONITOR_PRIORITY  = 5'h00;
  localparam logic [4:0] PWM_PRIORITY             = 5'h1c;
  localparam logic [4:0] EXT_LINE3_PRIORITY       = 5'h18;
  localparam logic [4:0] EXT_LINE2_PRIORITY       = 5'h14;
  localparam logic [4:0] EXT_LINE1_PRIORITY       = 5'h10;
  localparam logic [4:0] EXT_LINE0_PRIORITY       = 5'h0c;
  localparam logic [4:0] I2C_B_SLAVE_PRIORITY     = 5'h08;
  localparam logic [4:0] I2C_B_MASTER_PRIORITY    = 5'h04;
  localparam logic [4:0] I2C_A_SLAVE_PRIORITY     = 5'h00;
  localparam logic [4:0] LOGIC_ARRAY_B_PRIORITY   = 5'h0c;
  localparam logic [4:0] LOGIC_ARRAY_A_PRIORITY   = 5'h08;
  localparam logic [4:0] EXT_LINE5_PRIORITY       = 5'h04;
  localparam logic [4:0] EXT_LINE4_PRIORITY       = 5'h00;
  // Per source: {has field, register index, field lsb}
  localparam logic [7:0] SRC_FIELD [NUM_SRC] = '{
    8'h00, {3'h4, SOFT_SOURCE_PRIORITY}, {3'h4, TIMER0_PRIORITY},
    {3'h4, TIMER1_PRIORITY}, {3'h4, TIMER2_PRIORITY},
    {3'h4, TIMER3_PRIORITY}, {3'h4, TIMER4_PRIORITY},
    {3'h5, FLASH_A_PRIORITY}, {3'h5, FLASH_B_PRIORITY},
    {3'h5, CONVERTER_PRIORITY}, {3'h5, UART_PRIORITY},
    {3'h5, SPI_PRIORITY}, {3'h5, I2C_A_MASTER_PRIORITY},
    {3'h5, SUPPLY_MONITOR_PRIORITY}, {3'h6, I2C_A_SLAVE_PRIORITY},
    {3'h6, I2C_B_MASTER_PRIORITY}, {3'h6, I2C_B_SLAVE_PRIORITY},
    {3'h6, EXT_LINE0_PRIORITY}, {3'h6, EXT_LINE1_PRIORITY},
    {3'h6, EXT_LINE2_PRIORITY}, {3'h6, EXT_LINE3_PRIORITY},
    {3'h6, PWM_PRIORITY}, {3'h7, EXT_LINE4_PRIORITY},
    {3'h7, EXT_LINE5_PRIORITY}, {3'h7, LOGIC_ARRAY_A_PRIORITY},
    {3'h7, LOGIC_ARRAY_B_PRIORITY}, 8'h00, 8'h00};
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       found;
    logic [4:0] id;
    logic [2:0] level;
  } pick_t;
endpackage

// File: testbench.sv
// Self-checking bench for the priority and nesting block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic normal_irq, fast_irq, event_irq;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [4:0] fast_source;
  logic [27:0] normal_src, fast_src, normal_pending, fast_pending;
  int fails, samples_checked, cyc;
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  interrupt_priority_nesting dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .normal_pending(normal_pending),
    .fast_pending(fast_pending), .normal_irq(normal_irq),
    .fast_irq(fast_irq), .fast_source(fast_source),
    .event_irq(event_irq));
  core_model #(.LAG(1)) far (.aclk(aclk), .aresetn(aresetn),
    .normal_src(normal_src), .fast_src(fast_src),
    .normal_pending(normal_pending), .fast_pending(fast_pending));
  // ----------------------------------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d, logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(bvalid === 1'b1 && aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rdreg(logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(string what, logic [31:0] a, logic [31:0] exp);
    rdreg(a);
    chk(what, exp, rd);
  endtask
  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_fields();
    logic [31:0] a [4] = '{irq_nest_pkg::ADDR_PRIO0,
      irq_nest_pkg::ADDR_PRIO1, irq_nest_pkg::ADDR_PRIO2,
      irq_nest_pkg::ADDR_PRIO3};
    logic [31:0] m [4] = '{32'h0777_7770, 32'h7777_7707,
      32'h7777_7777, 32'h0000_7777};
    for (int i = 0; i < 4; i++) begin
      rchk("prio reset", a[i], 32'h0000_0000);
      wr(a[i], 32'hffff_ffff, irq_nest_pkg::RESP_OKAY);
      rchk("prio fields", a[i], m[i]);
      wr(a[i], 32'h0000_0000, irq_nest_pkg::RESP_OKAY);
    end
    rchk("ctrl reset", irq_nest_pkg::ADDR_NEST_CTL, 32'h0000_0000);
    rchk("in-service reset", irq_nest_pkg::ADDR_IN_SERV, 32'h0000_0000);
    rdreg(32'hffff_0050);
    chk("unmapped rresp", {30'h0, irq_nest_pkg::RESP_SLVERR}, {30'h0, rs});
  endtask
  task automatic t_no_nest();
    for (int c = 0; c < 4; c++) begin
      // Only the two defined control bits are ever written
      wr(irq_nest_pkg::ADDR_NEST_CTL, c, irq_nest_pkg::RESP_OKAY);
      normal_src <= 28'h000_0004;
      fast_src <= 28'h000_0020;
      settle();
      chk("fast_irq", 32'h1, {31'h0, fast_irq});
      chk("fast_source", 32'h5, {27'h0, fast_source});
      chk("normal_irq", c != 0, {31'h0, normal_irq});
    end
    normal_src <= 28'h000_0000;
    fast_src <= 28'h000_0000;
    settle();
  endtask
  task automatic t_nest();
    wr(irq_nest_pkg::ADDR_VEC_BASE, 32'h0000_1234, irq_nest_pkg::RESP_OKAY);
    wr(irq_nest_pkg::ADDR_PRIO0, 32'h0000_0300, irq_nest_pkg::RESP_OKAY);
    wr(irq_nest_pkg::ADDR_NEST_CTL, 32'h1, irq_nest_pkg::RESP_OKAY);
    normal_src <= 28'h000_0004;
    settle();
    rchk("vector", irq_nest_pkg::ADDR_VEC_PTR, 32'h0009_1a08);
    rchk("in-service", irq_nest_pkg::ADDR_IN_SERV, 32'h08);
    settle();
    chk("blocked irq", 32'h0, {31'h0, normal_irq});
    normal_src <= 28'h000_000c;
    settle();
    chk("level 0 irq", 32'h1, {31'h0, normal_irq});
    rchk("vector", irq_nest_pkg::ADDR_VEC_PTR, 32'h0009_1a0c);
    rchk("in-service", irq_nest_pkg::ADDR_IN_SERV, 32'h09);
    settle();
    chk("all blocked", 32'h0, {31'h0, normal_irq});
    wr(irq_nest_pkg::ADDR_IN_SERV, 32'hff, irq_nest_pkg::RESP_OKAY);
    rchk("one clear", irq_nest_pkg::ADDR_IN_SERV, 32'h08);
    settle();
    chk("unblocked", 32'h1, {31'h0, normal_irq});
    wr(irq_nest_pkg::ADDR_IN_SERV, 32'hff, irq_nest_pkg::RESP_OKAY);
    rchk("two clears", irq_nest_pkg::ADDR_IN_SERV, 32'h00);
    normal_src <= 28'h000_0000;
    settle();
  endtask
  task automatic t_events();
    wr(irq_nest_pkg::ADDR_EV_MASK, 32'h0, irq_nest_pkg::RESP_OKAY);
    wr(irq_nest_pkg::ADDR_EV_STAT, 32'h3, irq_nest_pkg::RESP_OKAY);
    rchk("event clear", irq_nest_pkg::ADDR_EV_STAT, 32'h0);
    normal_src <= 28'h000_0004;
    settle();
    rchk("event set", irq_nest_pkg::ADDR_EV_STAT, 32'h1);
    chk("event masked", 32'h0, {31'h0, event_irq});
    wr(irq_nest_pkg::ADDR_EV_MASK, 32'h3, irq_nest_pkg::RESP_OKAY);
    settle();
    chk("event mask", 32'h1, {31'h0, event_irq});
    normal_src <= 28'h000_0000;
    wr(irq_nest_pkg::ADDR_EV_STAT, 32'h1, irq_nest_pkg::RESP_OKAY);
    settle();
    chk("event_irq", 32'h0, {31'h0, event_irq});
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
    wstrb = 4'hf;
    normal_src = 28'h000_0000;
    fast_src = 28'h000_0000;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_fields();
    t_no_nest();
    t_nest();
    t_events();
    report_and_stop();
  end
endmodule
`default_nettype wire
